//--- hdl/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

    // --------------------------------------------------------------
    // Register map (word addresses)
    // --------------------------------------------------------------
    localparam logic [6:0] SLOT_LAST_ADDR = 7'h3F;
    localparam logic [6:0] IRQ_ENABLE_ADDR = 7'h40;
    localparam logic [6:0] IRQ_STATUS_ADDR = 7'h41;
    localparam logic [0:0] SEQ_CTRL_ADDR   = 1'h0;

    // --------------------------------------------------------------
    // Field layout and reset values
    // --------------------------------------------------------------
    localparam int RUN_BIT      = 0;
    localparam int MODE_LSB     = 1;
    localparam int MODE_W       = 3;
    localparam int LO_SAMPLE_LSB = 0;
    localparam int HI_SAMPLE_LSB = 16;
    localparam int SAMPLE_W     = 12;
    localparam int CHAN_W       = 5;
    localparam logic IRQ_ENABLE_RST = 1'b1;

    // --------------------------------------------------------------
    // Sequencer modes and channel codes
    // --------------------------------------------------------------
    localparam logic [2:0] MODE_CONT  = 3'h0;
    localparam logic [2:0] MODE_SINGLE = 3'h1;
    localparam logic [2:0] MODE_RECAL = 3'h7;
    localparam logic [4:0] CHAN_RECAL = 5'h1F;
    localparam logic [4:0] CHAN_TEMP  = 5'h11;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_RECAL} seq_state_t;

endpackage

//--- hdl/adc_seq_store.sv
// Notes on behaviour
// R01 - Command accepted when valid and ready high
// R02 - Channel 31 recal, 17 temp, 0-16 inputs
// R03 - Start flag marks first slot command
// R04 - End flag marks final slot command
// R05 - Packet flags copied from command to response
// R06 - Response stream never stalls; sink keeps up
// R07 - Response carries 5-bit source channel
// R08 - Data is 12 bits, 24 for dual
// R09 - Threshold event: one-cycle valid with channel
// R10 - Threshold data 1 above max, 0 below
// R11 - Word-addressed 32-bit register ports, 7/1 bits
// R12 - One shared clock for every sub-core
// R13 - One reset returns all state to initial
// R14 - Mode bits 3:1: 7 recal, 1 single, 0 continuous
// R15 - Mode writes ignored while run is set
// R16 - Continuous mode repeats the slot sequence
// R17 - Run bit change waits for current pass
// R18 - Slot words 0-3F, samples at 11:0, 27:16
// R19 - Enable bit 0 gates interrupt, resets to 1
// R20 - Status bit set on block end, self-clears
// R21 - Slots counted from start; end marks block
// R22 - Interrupt high when status and enable set
`timescale 1ns/1ps
module adc_seq_store #(
    parameter int NUM_SLOTS = 64,
    parameter int DUAL      = 0,
    parameter logic [5*64-1:0] SLOT_CHANNELS = '0
) (
    input  wire logic                    clk_i,  // see R12
    input  wire logic                    rst_i,
    // Sequencer register port
    input  wire logic                    seq_addr_i,
    input  wire logic                    seq_read_i,
    input  wire logic                    seq_write_i,
    input  wire logic [31:0]             seq_wdata_i,
    output logic      [31:0]             seq_rdata_o,
    // Sample storage register port
    input  wire logic [6:0]              st_addr_i,
    input  wire logic                    st_read_i,
    input  wire logic                    st_write_i,
    input  wire logic [31:0]             st_wdata_i,
    output logic      [31:0]             st_rdata_o,
    output logic                         irq_o,
    // Command stream to converter control
    output logic                         cmd_valid_o,
    input  wire logic                    cmd_ready_i,
    output logic      [4:0]              cmd_channel_o,
    output logic                         cmd_sop_o,
    output logic                         cmd_eop_o,
    // Converter result, one per slot command
    input  wire logic                    cnv_valid_i,
    input  wire logic [23:0]             cnv_data_i,
    input  wire logic [4:0]              cnv_channel_i,
    input  wire logic                    cnv_sop_i,
    input  wire logic                    cnv_eop_i,
    input  wire logic                    cnv_above_i,
    input  wire logic                    cnv_below_i,
    // Response stream, no ready
    output logic                         rsp_valid_o,
    output logic      [4:0]              rsp_channel_o,
    output logic      [12*(DUAL+1)-1:0]  rsp_data_o,
    output logic                         rsp_sop_o,
    output logic                         rsp_eop_o,
    // Threshold stream, no ready
    output logic                         thr_valid_o,
    output logic      [4:0]              thr_channel_o,
    output logic                         thr_data_o
);

    localparam int DW = 12 * (DUAL + 1);  // see R08

    if (NUM_SLOTS < 1 || NUM_SLOTS > 64) begin : g_bad_slots
        $error("NUM_SLOTS must be 1 to 64");
    end
    if (DUAL != 0 && DUAL != 1) begin : g_bad_dual
        $error("DUAL must be 0 or 1");
    end

    // --------------------------------------------------------------
    // Sequencer control register
    // --------------------------------------------------------------
    logic                       run_q;
    logic [2:0]                 mode_q;
    logic                       run_req_q;
    adc_ctrl_pkg::seq_state_t   state_q;
    logic [5:0]                 slot_q;
    logic                       cmd_fire;
    logic                       pass_end;
    logic                       seq_wr;
    logic                       seq_stop;

    assign seq_wr   = seq_write_i && seq_addr_i == adc_ctrl_pkg::SEQ_CTRL_ADDR;
    assign cmd_fire = cmd_valid_o && cmd_ready_i;                // see R01
    assign pass_end = cmd_fire && cmd_eop_o;
    // A run request is used up once a single pass or a recal ends
    assign seq_stop = (state_q == adc_ctrl_pkg::SEQ_RUN && pass_end
                       && mode_q != adc_ctrl_pkg::MODE_CONT)
                   || (state_q == adc_ctrl_pkg::SEQ_RECAL && cmd_fire);

    // Requested run level; applied only between passes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin                                         // see R13
            run_req_q <= 1'b0;
        end else if (seq_wr) begin
            run_req_q <= seq_wdata_i[adc_ctrl_pkg::RUN_BIT];
        end else if (seq_stop) begin                             // see R17
            run_req_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q <= adc_ctrl_pkg::MODE_CONT;                   // see R14
        end else if (seq_wr && !run_q) begin                     // see R15
            mode_q <= seq_wdata_i[adc_ctrl_pkg::MODE_LSB +: 3];
        end
    end

    // --------------------------------------------------------------
    // Sequencer state machine
    // --------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= adc_ctrl_pkg::SEQ_IDLE;
            run_q   <= 1'b0;
            slot_q  <= '0;
        end else begin
            case (state_q)
                adc_ctrl_pkg::SEQ_IDLE: begin
                    slot_q <= '0;
                    if (run_req_q) begin                         // see R17
                        run_q <= 1'b1;
                        if (mode_q == adc_ctrl_pkg::MODE_RECAL)
                            state_q <= adc_ctrl_pkg::SEQ_RECAL;
                        else if (mode_q == adc_ctrl_pkg::MODE_CONT
                                 || mode_q == adc_ctrl_pkg::MODE_SINGLE)
                            state_q <= adc_ctrl_pkg::SEQ_RUN;
                        else
                            run_q <= 1'b0;  // Reserved modes do nothing
                    end
                end
                adc_ctrl_pkg::SEQ_RUN: begin
                    if (cmd_fire) begin
                        if (cmd_eop_o) begin
                            slot_q <= '0;
                            // Stop request honoured only at pass end
                            if (mode_q == adc_ctrl_pkg::MODE_CONT
                                && run_req_q) begin              // see R16
                                state_q <= adc_ctrl_pkg::SEQ_RUN;
                            end else begin                       // see R17
                                state_q <= adc_ctrl_pkg::SEQ_IDLE;
                                run_q   <= 1'b0;
                            end
                        end else begin
                            slot_q <= slot_q + 6'h1;
                        end
                    end
                end
                adc_ctrl_pkg::SEQ_RECAL: begin
                    if (cmd_fire) begin
                        state_q <= adc_ctrl_pkg::SEQ_IDLE;
                        run_q   <= 1'b0;
                    end
                end
                default: state_q <= adc_ctrl_pkg::SEQ_IDLE;
            endcase
        end
    end

    // Command outputs registered from next-state view
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_valid_o   <= 1'b0;
            cmd_channel_o <= '0;
            cmd_sop_o     <= 1'b0;
            cmd_eop_o     <= 1'b0;
        end else if (!cmd_valid_o || cmd_fire) begin
            cmd_valid_o <= 1'b0;
            cmd_sop_o   <= 1'b0;
            cmd_eop_o   <= 1'b0;
            if (state_q == adc_ctrl_pkg::SEQ_RUN && !(pass_end &&
                !(mode_q == adc_ctrl_pkg::MODE_CONT && run_req_q))) begin
                logic [5:0] nxt;
                nxt = pass_end ? 6'h0 :
                      (cmd_fire ? slot_q + 6'h1 : slot_q);
                cmd_valid_o   <= 1'b1;
                cmd_channel_o <= SLOT_CHANNELS[nxt*5 +: 5];
                cmd_sop_o     <= (nxt == 6'h0);                  // see R03
                cmd_eop_o     <= (nxt == 6'(NUM_SLOTS - 1));     // see R04
            end else if (state_q == adc_ctrl_pkg::SEQ_RECAL
                         && !cmd_fire) begin
                cmd_valid_o   <= 1'b1;
                cmd_channel_o <= adc_ctrl_pkg::CHAN_RECAL;       // see R02
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seq_rdata_o <= '0;
        end else if (seq_read_i) begin
            seq_rdata_o <= {28'h0, mode_q, run_q};
        end
    end

    // --------------------------------------------------------------
    // Response and threshold streams
    // --------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rsp_valid_o   <= 1'b0;
            rsp_channel_o <= '0;
            rsp_data_o    <= '0;
            rsp_sop_o     <= 1'b0;
            rsp_eop_o     <= 1'b0;
        end else begin
            rsp_valid_o   <= cnv_valid_i;                        // see R06
            rsp_channel_o <= cnv_channel_i;                      // see R07
            rsp_data_o    <= cnv_data_i[DW-1:0];                 // see R08
            rsp_sop_o     <= cnv_valid_i && cnv_sop_i;           // see R05
            rsp_eop_o     <= cnv_valid_i && cnv_eop_i;           // see R05
        end
    end

    // Max crossing reported when both limits flag at once
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            thr_valid_o   <= 1'b0;
            thr_channel_o <= '0;
            thr_data_o    <= 1'b0;
        end else begin
            thr_valid_o   <= cnv_valid_i && (cnv_above_i || cnv_below_i);
            thr_channel_o <= cnv_channel_i;                      // see R09
            thr_data_o    <= cnv_above_i;                        // see R10
        end
    end

    // --------------------------------------------------------------
    // Sample storage
    // --------------------------------------------------------------
    logic [DW-1:0] slot_mem_q [64];
    logic [5:0]    wr_slot_q;
    logic [5:0]    wr_idx;
    logic          ier_q;
    logic          isr_q;
    logic          isr_shown_q;

    assign wr_idx = rsp_sop_o ? 6'h0 : wr_slot_q;                // see R21

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_slot_q <= '0;
        end else if (rsp_valid_o) begin
            wr_slot_q <= rsp_eop_o ? 6'h0 : wr_idx + 6'h1;
        end
    end

    for (genvar s = 0; s < 64; s++) begin : g_slot
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                slot_mem_q[s] <= '0;
            end else if (rsp_valid_o && wr_idx == 6'(s)) begin
                slot_mem_q[s] <= rsp_data_o;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ier_q <= adc_ctrl_pkg::IRQ_ENABLE_RST;               // see R19
        end else if (st_write_i
                     && st_addr_i == adc_ctrl_pkg::IRQ_ENABLE_ADDR) begin
            ier_q <= st_wdata_i[0];
        end
    end

    // Status self-clears the cycle after it was shown; new event wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            isr_q       <= 1'b0;
            isr_shown_q <= 1'b0;
        end else begin
            isr_shown_q <= isr_q;
            if (rsp_valid_o && rsp_eop_o)                        // see R20
                isr_q <= 1'b1;
            else if (isr_shown_q)
                isr_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= isr_q && ier_q;                             // see R22
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_rdata_o <= '0;
        end else if (st_read_i) begin                            // see R11
            st_rdata_o <= '0;
            if (st_addr_i <= adc_ctrl_pkg::SLOT_LAST_ADDR) begin // see R18
                st_rdata_o[adc_ctrl_pkg::LO_SAMPLE_LSB +: 12] <=
                    slot_mem_q[st_addr_i[5:0]][11:0];
                if (DUAL == 1)
                    st_rdata_o[adc_ctrl_pkg::HI_SAMPLE_LSB +: 12] <=
                        slot_mem_q[st_addr_i[5:0]][DW-1 -: 12];
            end else if (st_addr_i == adc_ctrl_pkg::IRQ_ENABLE_ADDR) begin
                st_rdata_o[0] <= ier_q;
            end else if (st_addr_i == adc_ctrl_pkg::IRQ_STATUS_ADDR) begin
                st_rdata_o[0] <= isr_q;
            end
        end
    end

endmodule // adc_seq_store

//--- tb/adc_seq_store_monitor.sv
`timescale 1ns/1ps
module adc_seq_store_monitor #(
    parameter int              NUM_SLOTS     = 64,
    parameter int              DUAL          = 0,
    parameter logic [5*64-1:0] SLOT_CHANNELS = '0
) (
    input wire logic                   clk_i,
    input wire logic                   rst_i,
    input wire logic [6:0]             st_addr_i,
    input wire logic                   st_write_i,
    input wire logic [31:0]            st_wdata_i,
    input wire logic                   irq_o,
    input wire logic                   cmd_valid_o,
    input wire logic                   cmd_ready_i,
    input wire logic [4:0]             cmd_channel_o,
    input wire logic                   cmd_sop_o,
    input wire logic                   cmd_eop_o,
    input wire logic                   cnv_valid_i,
    input wire logic [23:0]            cnv_data_i,
    input wire logic [4:0]             cnv_channel_i,
    input wire logic                   cnv_sop_i,
    input wire logic                   cnv_eop_i,
    input wire logic                   cnv_above_i,
    input wire logic                   cnv_below_i,
    input wire logic                   rsp_valid_o,
    input wire logic [4:0]             rsp_channel_o,
    input wire logic [12*(DUAL+1)-1:0] rsp_data_o,
    input wire logic                   rsp_sop_o,
    input wire logic                   rsp_eop_o,
    input wire logic                   thr_valid_o,
    input wire logic [4:0]             thr_channel_o,
    input wire logic                   thr_data_o
);
    logic [6:0] slot_q;
    logic       ier_q;
    // Recal is not a slot, so it must not move the position
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slot_q <= 7'h00;
        end else if (cmd_valid_o && cmd_ready_i
                     && cmd_channel_o != adc_ctrl_pkg::CHAN_RECAL) begin
            slot_q <= cmd_eop_o ? 7'h00 : slot_q + 7'h01;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ier_q <= 1'b1;
        end else if (st_write_i
                     && st_addr_i == adc_ctrl_pkg::IRQ_ENABLE_ADDR) begin
            ier_q <= st_wdata_i[0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_slot_cmd;
        cmd_valid_o && cmd_channel_o != adc_ctrl_pkg::CHAN_RECAL;
    endsequence
    sequence s_block_end;
        rsp_valid_o && rsp_eop_o && ier_q;
    endsequence
    sequence s_limit;
        cnv_valid_i && (cnv_above_i || cnv_below_i);
    endsequence
    cmd_hold_a:
        assert property (cmd_valid_o && !cmd_ready_i |=> cmd_valid_o
            && $stable({cmd_channel_o, cmd_sop_o, cmd_eop_o}))
        else $error("command changed while waiting");
    slot_chan_a:
        assert property (s_slot_cmd
            |-> cmd_channel_o == SLOT_CHANNELS[slot_q*5 +: 5])
        else $error("wrong slot channel");
    first_sop_a:
        assert property (s_slot_cmd |-> cmd_sop_o == (slot_q == 0))
        else $error("start flag misplaced");
    last_eop_a:
        assert property (s_slot_cmd
            |-> cmd_eop_o == (slot_q == NUM_SLOTS - 1))
        else $error("end flag misplaced");
    flag_copy_a:
        assert property (cnv_valid_i |=> rsp_valid_o
            && rsp_sop_o == $past(cnv_sop_i)
            && rsp_eop_o == $past(cnv_eop_i))
        else $error("response flags not copied");
    rsp_fields_a:
        assert property (cnv_valid_i |=> rsp_channel_o == $past(cnv_channel_i)
            && rsp_data_o == $past(cnv_data_i[12*(DUAL+1)-1:0]))
        else $error("response channel or data wrong");
    thr_event_a:
        assert property (s_limit |=> thr_valid_o
            && thr_channel_o == $past(cnv_channel_i)
            && thr_data_o == $past(cnv_above_i))
        else $error("threshold event wrong");
    thr_quiet_a:
        assert property (!(cnv_valid_i && (cnv_above_i || cnv_below_i))
            |=> !thr_valid_o)
        else $error("spurious threshold event");
    irq_raise_a:
        assert property (s_block_end |-> ##[1:4] irq_o)
        else $error("block end gave no interrupt");
    irq_mask_a:
        assert property (!ier_q && !$past(ier_q) |-> !irq_o)
        else $error("masked interrupt raised");
    irq_clear_a:
        assert property ($rose(irq_o) |-> ##[1:4] !irq_o)
        else $error("interrupt did not self clear");
endmodule // adc_seq_store_monitor

bind adc_seq_store adc_seq_store_monitor #(.NUM_SLOTS(NUM_SLOTS),
    .DUAL(DUAL), .SLOT_CHANNELS(SLOT_CHANNELS)) mon (
    .clk_i(clk_i), .rst_i(rst_i), .st_addr_i(st_addr_i),
    .st_write_i(st_write_i), .st_wdata_i(st_wdata_i), .irq_o(irq_o),
    .cmd_valid_o(cmd_valid_o), .cmd_ready_i(cmd_ready_i),
    .cmd_channel_o(cmd_channel_o), .cmd_sop_o(cmd_sop_o),
    .cmd_eop_o(cmd_eop_o), .cnv_valid_i(cnv_valid_i),
    .cnv_data_i(cnv_data_i), .cnv_channel_i(cnv_channel_i),
    .cnv_sop_i(cnv_sop_i), .cnv_eop_i(cnv_eop_i),
    .cnv_above_i(cnv_above_i), .cnv_below_i(cnv_below_i),
    .rsp_valid_o(rsp_valid_o), .rsp_channel_o(rsp_channel_o),
    .rsp_data_o(rsp_data_o), .rsp_sop_o(rsp_sop_o),
    .rsp_eop_o(rsp_eop_o), .thr_valid_o(thr_valid_o),
    .thr_channel_o(thr_channel_o), .thr_data_o(thr_data_o));

//--- tb/adc_conv_model.sv
`timescale 1ns/1ps
module adc_conv_model (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        slow_i,
    input wire logic        cmd_valid_i,
    input wire logic [4:0]  cmd_channel_i,
    input wire logic        cmd_sop_i,
    input wire logic        cmd_eop_i,
    output logic            cmd_ready_o,
    output logic            cnv_valid_o,
    output logic [23:0]     cnv_data_o,
    output logic [4:0]      cnv_channel_o,
    output logic            cnv_sop_o,
    output logic            cnv_eop_o,
    output logic            cnv_above_o,
    output logic            cnv_below_o
);
    logic [2:0]  wait_q;
    logic [11:0] smp;
    assign cmd_ready_o = wait_q == 3'h0 && !rst_i;
    assign smp = {7'h2B, cnv_channel_o};
    // Idle data is inverted so stale values never look valid
    assign cnv_data_o = cnv_valid_o ? {~smp, smp} : {smp, ~smp};
    assign cnv_above_o = cnv_valid_o && cnv_channel_o == 5'h05;
    assign cnv_below_o = cnv_valid_o && cnv_channel_o == 5'h11;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wait_q <= 3'h0;
            cnv_valid_o <= 1'b0;
            cnv_channel_o <= 5'h00;
            {cnv_sop_o, cnv_eop_o} <= 2'h0;
        end else if (cmd_valid_i && cmd_ready_o) begin
            wait_q <= slow_i ? 3'h5 : 3'h2;
            cnv_valid_o <= 1'b0;
            cnv_channel_o <= cmd_channel_i;
            {cnv_sop_o, cnv_eop_o} <= {cmd_sop_i, cmd_eop_i};
        end else begin
            // Recalibration yields no sample
            cnv_valid_o <= wait_q == 3'h1
                && cnv_channel_o != adc_ctrl_pkg::CHAN_RECAL;
            if (wait_q != 3'h0) begin
                wait_q <= wait_q - 3'h1;
            end
        end
    end
endmodule // adc_conv_model

//--- tb/adc_seq_store_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module adc_seq_store_tb;
    localparam int           SLOTS = 3;
    localparam logic [319:0] CHANS = {305'h0, 5'h11, 5'h05, 5'h00};
    logic        clk_i, rst_i, slow, irq_o, irq_p, last_eop;
    logic        seq_addr_i, seq_read_i, seq_write_i, st_read_i, st_write_i;
    logic [31:0] seq_wdata_i, seq_rdata_o, st_wdata_i, st_rdata_o, rd_q, exp_w;
    logic [6:0]  st_addr_i;
    logic        cmd_valid_o, cmd_ready_i, cmd_sop_o, cmd_eop_o;
    logic [4:0]  cmd_channel_o, cnv_channel_i, rsp_channel_o, thr_channel_o;
    logic        cnv_valid_i, cnv_sop_i, cnv_eop_i, cnv_above_i, cnv_below_i;
    logic [23:0] cnv_data_i;
    logic [11:0] rsp_data_o;
    logic        rsp_valid_o, rsp_sop_o, rsp_eop_o, thr_valid_o, thr_data_o;
    int          fails, checks_done, cycles, eops, irqs, thrs, recals, i;
    adc_seq_store #(.NUM_SLOTS(SLOTS), .DUAL(0), .SLOT_CHANNELS(CHANS)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .seq_addr_i(seq_addr_i),
        .seq_read_i(seq_read_i), .seq_write_i(seq_write_i),
        .seq_wdata_i(seq_wdata_i), .seq_rdata_o(seq_rdata_o),
        .st_addr_i(st_addr_i), .st_read_i(st_read_i), .st_write_i(st_write_i),
        .st_wdata_i(st_wdata_i), .st_rdata_o(st_rdata_o), .irq_o(irq_o),
        .cmd_valid_o(cmd_valid_o), .cmd_ready_i(cmd_ready_i),
        .cmd_channel_o(cmd_channel_o), .cmd_sop_o(cmd_sop_o),
        .cmd_eop_o(cmd_eop_o), .cnv_valid_i(cnv_valid_i),
        .cnv_data_i(cnv_data_i), .cnv_channel_i(cnv_channel_i),
        .cnv_sop_i(cnv_sop_i), .cnv_eop_i(cnv_eop_i),
        .cnv_above_i(cnv_above_i), .cnv_below_i(cnv_below_i),
        .rsp_valid_o(rsp_valid_o), .rsp_channel_o(rsp_channel_o),
        .rsp_data_o(rsp_data_o), .rsp_sop_o(rsp_sop_o), .rsp_eop_o(rsp_eop_o),
        .thr_valid_o(thr_valid_o), .thr_channel_o(thr_channel_o),
        .thr_data_o(thr_data_o));
    adc_conv_model conv (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
        .cmd_valid_i(cmd_valid_o), .cmd_channel_i(cmd_channel_o),
        .cmd_sop_i(cmd_sop_o), .cmd_eop_i(cmd_eop_o),
        .cmd_ready_o(cmd_ready_i), .cnv_valid_o(cnv_valid_i),
        .cnv_data_o(cnv_data_i), .cnv_channel_o(cnv_channel_i),
        .cnv_sop_o(cnv_sop_i), .cnv_eop_o(cnv_eop_i),
        .cnv_above_o(cnv_above_i), .cnv_below_o(cnv_below_i));
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    // Every block-end response is counted in its own cycle: the stream cannot stall
    always @(posedge clk_i) begin
        if (rsp_valid_o && rsp_eop_o) eops++;
        if (thr_valid_o) thrs++;
        if (irq_o && !irq_p) irqs++;
        irq_p = irq_o;
        if (cmd_valid_o && cmd_ready_i) begin
            last_eop = cmd_eop_o;
            if (cmd_channel_o == adc_ctrl_pkg::CHAN_RECAL) recals++;
        end
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            end_of_test();
        end
    end
    task wr(input logic sq, input logic [6:0] a, input logic [31:0] d);
        @(posedge clk_i) #1;
        if (sq) {seq_write_i, seq_addr_i, seq_wdata_i} = {1'b1, a[0], d};
        else {st_write_i, st_addr_i, st_wdata_i} = {1'b1, a, d};
        @(posedge clk_i) #1;
        {seq_write_i, st_write_i} = 2'h0;
    endtask
    task rd(input logic sq, input logic [6:0] a);
        @(posedge clk_i) #1;
        if (sq) {seq_read_i, seq_addr_i} = {1'b1, a[0]};
        else {st_read_i, st_addr_i} = {1'b1, a};
        @(posedge clk_i) #1;
        {seq_read_i, st_read_i} = 2'h0;
        rd_q = sq ? seq_rdata_o : st_rdata_o;
    endtask
    // Run bit drops at the last command; the last sample lands later
    task wait_idle;
        for (i = 0; i < 60; i++) begin
            rd(1'b1, 7'h00);
            if (rd_q[0] === 1'b0) break;
        end
        for (i = 0; i < 20 && cmd_ready_i !== 1'b1; i++) @(posedge clk_i);
        repeat (6) @(posedge clk_i);
    endtask
    task run_pass(input logic [31:0] cmd);
        {eops, irqs, thrs, recals} = '0;
        wr(1'b1, 7'h00, cmd);
        wait_idle();
    endtask
    task t_reset;
        rd(1'b1, 7'h00); `CHK("control", 32'h0, rd_q)
        rd(1'b0, 7'h40); `CHK("irq enable", 32'h1, rd_q)
        rd(1'b0, 7'h41); `CHK("irq status", 32'h0, rd_q)
        rd(1'b0, 7'h00); `CHK("slot 0", 32'h0, rd_q)
        $display("test reset done");
    endtask
    task t_single;
        slow = 1'b1;
        run_pass(32'h3);
        `CHK("block ends", 1, eops)
        `CHK("irq pulses", 1, irqs)
        `CHK("limit events", 2, thrs)
        rd(1'b1, 7'h00); `CHK("control", 32'h2, rd_q)
        for (int s = 0; s < 4; s++) begin
            rd(1'b0, s[6:0]);
            exp_w = (s < SLOTS) ? {20'h0, 7'h2B, CHANS[s*5 +: 5]} : 32'h0;
            `CHK("slot", exp_w, rd_q)
        end
        $display("test single done");
    endtask
    task t_cont;
        slow = 1'b0;
        eops = 0;
        wr(1'b1, 7'h00, 32'h1);
        for (i = 0; i < 300 && eops < 2; i++) @(posedge clk_i);
        `CHK("passes", 1'b1, eops >= 2)
        wr(1'b1, 7'h00, 32'hF);
        rd(1'b1, 7'h00); `CHK("locked mode", 32'h1, rd_q)
        wr(1'b1, 7'h00, 32'h0);
        wait_idle();
        `CHK("stop at end", 1'b1, last_eop)
        `CHK("no command", 1'b0, cmd_valid_o)
        $display("test continuous done");
    endtask
    task t_recal;
        run_pass(32'hF);
        `CHK("recal commands", 1, recals)
        rd(1'b1, 7'h00); `CHK("control", 32'hE, rd_q)
        $display("test recal done");
    endtask
    task t_mask;
        wr(1'b0, 7'h40, 32'h0);
        run_pass(32'h3);
        `CHK("masked irq", 0, irqs)
        `CHK("block ends", 1, eops)
        rd(1'b0, 7'h40); `CHK("irq enable", 32'h0, rd_q)
        wr(1'b0, 7'h40, 32'h1);
        $display("test mask done");
    endtask
    task t_ro;
        wr(1'b0, 7'h00, 32'hFFFFFFFF);
        wr(1'b0, 7'h41, 32'h1);
        rd(1'b0, 7'h00);
        `CHK("slot 0", {20'h0, 7'h2B, CHANS[4:0]}, rd_q)
        rd(1'b0, 7'h41); `CHK("irq status", 32'h0, rd_q)
        rd(1'b0, 7'h50); `CHK("unmapped", 32'h0, rd_q)
        $display("test read only done");
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        {rst_i, slow, irq_p, last_eop} = 4'h8;
        {seq_addr_i, seq_read_i, seq_write_i, st_read_i, st_write_i} = 5'h0;
        {seq_wdata_i, st_wdata_i, st_addr_i} = '0;
        repeat (8) @(posedge clk_i);
        #1 rst_i = 1'b0;
        t_reset();
        t_single();
        t_cont();
        t_recal();
        t_mask();
        t_ro();
        end_of_test();
    end
endmodule // adc_seq_store_tb
